// *** rtl/power_clock_manager_regs.v ***
// Power manager register bank, prescaler enables and clock gate control
`timescale 1ns/100ps
`include "pwr_clk_map.vh"

// Overview of operation
// - Register port handles 8, 16 and 32 bit accesses atomically.
// - Each byte and half of wide registers is reachable directly.
// - Write-protected registers ignore writes while the access guard locks them.
// - Bit 4 selects backup oscillator; hardware sets it on clock failure.
// - Bit 2 enables failure detector; hardware also sets it on failure.
// - Idle depth stops core, core plus high-speed, or all bus domains.
// - Idle depth applies when core executes wait-for-interrupt instruction.
// - Core prescaler divides main clock by two to the field value.
// - Bus A prescaler divides by two to the field value, 1 to 128.
// - Sources set flags; writing one clears, writing zero does nothing.
// - Enable-set write one enables, enable-clear write one disables.
// - Interrupt high while any enabled flag is set.
module power_clock_manager_regs
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // Register port
    input  wire [5:0]  reg_addr,
    input  wire [1:0]  reg_size,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Access guard lock, same clock domain
    input  wire        access_guard_lock,
    // Clock events from the oscillator logic
    input  wire        clock_ready_evt,
    input  wire        clock_failure_evt,
    // Core sleep request
    input  wire        wait_for_interrupt_instr,
    input  wire        wake_request,
    // Reset causes, sampled once after release
    input  wire [5:0]  reset_cause_in,
    // Clock control outputs
    output wire        backup_clock_select,
    output wire        failure_detector_enable,
    output wire        core_clk_en,
    output wire        bus_a_clk_en,
    output wire        bus_b_clk_en,
    output wire        bus_c_clk_en,
    output reg         core_domain_stop,
    output reg         hs_domain_stop,
    output reg         pb_domain_stop,
    output wire [31:0] hs_clock_gates,
    output wire [31:0] bus_a_clock_gates,
    output wire [31:0] bus_b_clock_gates,
    output wire [31:0] bus_c_clock_gates,
    // Interrupt
    output wire        irq
);

    // Software-visible register state
    reg  [7:0]  main_control_q;
    reg  [1:0]  sleep_config_q;
    reg  [2:0]  core_div_q;
    reg  [2:0]  bus_a_div_q;
    reg  [2:0]  bus_b_div_q;
    reg  [2:0]  bus_c_div_q;
    reg  [31:0] hs_gates_q;
    reg  [31:0] bus_a_gates_q;
    reg  [31:0] bus_b_gates_q;
    reg  [31:0] bus_c_gates_q;
    reg  [1:0]  irq_enable_q;
    reg  [1:0]  irq_flags_q;
    // Reset cause capture: two sync stages then a one-shot load
    reg  [5:0]  cause_sync1_q;
    reg  [5:0]  cause_sync2_q;
    reg  [5:0]  reset_cause_q;
    reg  [1:0]  cause_wait_q;
    reg         cause_taken_q;
    // Prescaler counter and bus decode helpers
    reg  [6:0]  presc_cnt_q;
    reg  [31:0] wr_mask;
    reg  [31:0] wr_data;
    reg  [31:0] rd_word;
    wire [5:0]  word_addr;
    wire        wr_ok;

    // Bus notes:
    // Size and the low address bits pick the byte lanes of one word
    // Halves are aligned by addr[1]; an odd half offset uses its half
    // Data always travels in the low bits and is moved to its lane here
    // Every access finishes in one cycle, so no wait state exists
    // Unmapped words ignore writes and read as zero

    // Byte lane mask for an access of given size at a byte offset
    function [31:0] lane_mask;
        input [1:0] size;
        input [1:0] ofs;
        begin
            if (size == `SIZE_WORD)
                lane_mask = 32'hFFFFFFFF;
            else if (size == `SIZE_HALF)
                lane_mask = ofs[1] ? 32'hFFFF0000 : 32'h0000FFFF;
            else
                lane_mask = 32'h000000FF << {ofs, 3'h0};
        end
    endfunction

    // Lane merge: keep untouched lanes, take new data in written ones
    function [31:0] merge_lanes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [31:0] mask;
        input [31:0] keep;
        begin
            merge_lanes = ((old_val & ~mask) | (new_val & mask)) & keep;
        end
    endfunction

    // Divider notes:
    // All four prescalers share one free-running 7-bit counter
    // Code n fires when the low n counter bits are all ones
    // So code 0 fires every cycle and code 7 once in 128 cycles
    // A new code takes effect at once; the first gap may be short
    // Sharing one counter keeps the enables of all buses aligned

    // Divider enable: pulse once every 2^sel cycles of the free counter
    function div_en;
        input [6:0] cnt;
        input [2:0] sel;
        reg   [6:0] low_bits;
        begin
            low_bits = (7'h7F >> (3'h7 - sel));
            div_en = ((cnt & low_bits) == low_bits);
        end
    endfunction

    // Byte-lane write data aligned into the word, lanes placed by offset
    assign word_addr = {reg_addr[5:2], 2'h0};
    assign wr_ok     = reg_wr & ~access_guard_lock;

    always @*
    begin
        wr_mask = lane_mask(reg_size, reg_addr[1:0]);
        wr_data = reg_wdata << {reg_addr[1:0], 3'h0};
    end

    // Word map seen by the write logic:
    // 0x00 lane 0 control bits 4 and 2, lane 1 idle depth
    // 0x08 lanes 0 to 3 core and three bus prescaler codes
    // 0x14 to 0x20 one clock gate mask word each
    // 0x34 lane 0 enable clear, lane 1 enable set, lane 2 flags
    // 0x38 lane 0 reset cause, read only
    // Guard lock blocks the first three groups, not the irq word
    // Reserved bits are masked so they always read back as zero

    // Register writes; hardware sets win over software writes
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            main_control_q <= 8'h00;
            sleep_config_q <= 2'h0;
            core_div_q     <= 3'h0;
            bus_a_div_q    <= 3'h0;
            bus_b_div_q    <= 3'h0;
            bus_c_div_q    <= 3'h0;
            hs_gates_q     <= `RST_HS_GATES;
            bus_a_gates_q  <= `RST_BUS_A_GATES;
            bus_b_gates_q  <= `RST_BUS_B_GATES;
            bus_c_gates_q  <= `RST_BUS_C_GATES;
            irq_enable_q   <= 2'h0;
            irq_flags_q    <= 2'h0;
        end
        else
        begin
            if (wr_ok && word_addr == `OFS_MAIN_CONTROL)
            begin
                // Offset 0 word holds control, sleep; byte lanes 0 and 1
                if (wr_mask[0])
                    main_control_q <= wr_data[7:0] & 8'h14;
                if (wr_mask[8])
                    sleep_config_q <= wr_data[9:8];
            end
            else if (wr_ok && word_addr == `OFS_CORE_DIV_SEL)
            begin
                // Bus selects expect byte writes only
                if (wr_mask[0])
                    core_div_q <= wr_data[2:0];
                if (wr_mask[8])
                    bus_a_div_q <= wr_data[10:8];
                if (wr_mask[16])
                    bus_b_div_q <= wr_data[18:16];
                if (wr_mask[24])
                    bus_c_div_q <= wr_data[26:24];
            end
            else if (wr_ok && word_addr == `OFS_HS_GATES)
                hs_gates_q <= merge_lanes(hs_gates_q, wr_data, wr_mask, `MASK_HS_GATES);
            else if (wr_ok && word_addr == `OFS_BUS_A_GATES)
                bus_a_gates_q <= merge_lanes(bus_a_gates_q, wr_data, wr_mask, `MASK_BUS_A_GATES);
            else if (wr_ok && word_addr == `OFS_BUS_B_GATES)
                bus_b_gates_q <= merge_lanes(bus_b_gates_q, wr_data, wr_mask, `MASK_BUS_B_GATES);
            else if (wr_ok && word_addr == `OFS_BUS_C_GATES)
                bus_c_gates_q <= merge_lanes(bus_c_gates_q, wr_data, wr_mask, `MASK_BUS_C_GATES);

            // Interrupt enables: set lane 1, clear lane 0
            if (reg_wr && word_addr == `OFS_IRQ_ENABLE_CLEAR)
            begin
                irq_enable_q <= (irq_enable_q
                                 & ~(wr_mask[0] ? wr_data[1:0] : 2'h0))
                                | (wr_mask[8] ? wr_data[9:8] : 2'h0);
            end

            // Flags share the word at offset 0x34, byte lane 2
            // Flags: write one clears, event in same cycle wins
            irq_flags_q <= (irq_flags_q
                            & ~((reg_wr && word_addr == `OFS_IRQ_ENABLE_CLEAR && wr_mask[16])
                                ? wr_data[17:16] : 2'h0))
                           | {clock_failure_evt & failure_detector_enable,
                              clock_ready_evt};

            // Clock failure forces backup clock and detector bits
            if (clock_failure_evt && main_control_q[`BIT_FAILURE_DET_EN])
            begin
                main_control_q[`BIT_BACKUP_CLK_SEL] <= 1'b1;
                main_control_q[`BIT_FAILURE_DET_EN] <= 1'b1;
            end
        end
    end

    // Cause notes:
    // The cause lines come from the reset logic, outside this clock
    // They pass two flops before anything reads them
    // Capture waits until the pipe holds real samples

    // Cause line synchroniser
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cause_sync1_q <= 6'h00;
            cause_sync2_q <= 6'h00;
        end
        else
        begin
            cause_sync1_q <= reset_cause_in;
            cause_sync2_q <= cause_sync1_q;
        end
    end

    // Load the synchronised cause once, after the pipe fills
    // Later changes on the cause lines wait for the next reset
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reset_cause_q <= 6'h00;
            cause_wait_q  <= 2'h0;
            cause_taken_q <= 1'b0;
        end
        else if (!cause_taken_q)
        begin
            if (cause_wait_q == 2'h2)
            begin
                reset_cause_q <= cause_sync2_q;
                cause_taken_q <= 1'b1;
            end
            else
                cause_wait_q <= cause_wait_q + 2'h1;
        end
    end

    // Read notes:
    // The whole word is built here and cut to the lanes on the strobe
    // Both enable lanes show the same enable bits
    // Cause bits 3 and 7 are unused and read zero

    // Read mux; unmapped addresses and reserved bits read zero
    always @*
    begin
        if (word_addr == `OFS_MAIN_CONTROL)
            rd_word = {16'h0000, 6'h00, sleep_config_q, main_control_q};
        else if (word_addr == `OFS_CORE_DIV_SEL)
            rd_word = {5'h00, bus_c_div_q, 5'h00, bus_b_div_q,
                       5'h00, bus_a_div_q, 5'h00, core_div_q};
        else if (word_addr == `OFS_HS_GATES)
            rd_word = hs_gates_q;
        else if (word_addr == `OFS_BUS_A_GATES)
            rd_word = bus_a_gates_q;
        else if (word_addr == `OFS_BUS_B_GATES)
            rd_word = bus_b_gates_q;
        else if (word_addr == `OFS_BUS_C_GATES)
            rd_word = bus_c_gates_q;
        else if (word_addr == `OFS_IRQ_ENABLE_CLEAR)
            rd_word = {14'h0000, irq_flags_q, 6'h00, irq_enable_q,
                       6'h00, irq_enable_q};
        else if (word_addr == `OFS_RESET_CAUSE_LOG)
            rd_word = {24'h000000, 1'b0, reset_cause_q[5:3], 1'b0,
                       reset_cause_q[2:0]};
        else
            rd_word = 32'h00000000;
    end

    // Read data one cycle later, shifted down to the accessed lane
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
            reg_rdata <= (rd_word & lane_mask(reg_size, reg_addr[1:0]))
                         >> {reg_addr[1:0], 3'h0};
    end

    // Counter notes:
    // Wraps every 128 cycles, the longest divide ratio
    // Never stopped, so enables keep running in every idle depth
    // Domain stops are applied by the clock gates downstream

    // Free-running prescaler counter; all dividers share it
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            presc_cnt_q <= 7'h00;
        else
            presc_cnt_q <= presc_cnt_q + 7'h01;
    end

    assign core_clk_en  = div_en(presc_cnt_q, core_div_q);
    assign bus_a_clk_en = div_en(presc_cnt_q, bus_a_div_q);
    assign bus_b_clk_en = div_en(presc_cnt_q, bus_b_div_q);
    assign bus_c_clk_en = div_en(presc_cnt_q, bus_c_div_q);

    // Idle notes:
    // Depth 0 stops core only, 1 adds the high-speed bus
    // Depth 2 also stops the peripheral buses
    // The stops nest: a deeper domain never stops alone
    // Wake beats a sleep request in the same cycle
    // Depth is read at the sleep request, so later writes wait
    // for the next sleep to take effect

    // Idle state entered on the sleep instruction, left on wake request
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            core_domain_stop <= 1'b0;
            hs_domain_stop   <= 1'b0;
            pb_domain_stop   <= 1'b0;
        end
        else if (wake_request)
        begin
            core_domain_stop <= 1'b0;
            hs_domain_stop   <= 1'b0;
            pb_domain_stop   <= 1'b0;
        end
        else if (wait_for_interrupt_instr)
        begin
            // Reserved depth code behaves as deepest stop
            core_domain_stop <= 1'b1;
            hs_domain_stop   <= (sleep_config_q != `IDLE_CORE);
            pb_domain_stop   <= (sleep_config_q[1]);
        end
    end

    // Output notes:
    // Control bits and gate masks go out straight from their flops
    // Interrupt is a level, low as soon as flag or enable drops

    assign backup_clock_select     = main_control_q[`BIT_BACKUP_CLK_SEL];
    assign failure_detector_enable = main_control_q[`BIT_FAILURE_DET_EN];
    assign hs_clock_gates          = hs_gates_q;
    assign bus_a_clock_gates       = bus_a_gates_q;
    assign bus_b_clock_gates       = bus_b_gates_q;
    assign bus_c_clock_gates       = bus_c_gates_q;
    assign irq                     = |(irq_flags_q & irq_enable_q);

endmodule // power_clock_manager_regs

// *** rtl/pwr_clk_map.vh ***
// Register offsets, field positions, reset values for the power clock manager
`ifndef PWR_CLK_MAP_VH
`define PWR_CLK_MAP_VH

// Byte offsets, all within one 64-byte window
`define OFS_MAIN_CONTROL      6'h00
`define OFS_SLEEP_CONFIG      6'h01
`define OFS_CORE_DIV_SEL      6'h08
`define OFS_BUS_A_DIV_SEL     6'h09
`define OFS_BUS_B_DIV_SEL     6'h0A
`define OFS_BUS_C_DIV_SEL     6'h0B
`define OFS_HS_GATES          6'h14
`define OFS_BUS_A_GATES       6'h18
`define OFS_BUS_B_GATES       6'h1C
`define OFS_BUS_C_GATES       6'h20
`define OFS_IRQ_ENABLE_CLEAR  6'h34
`define OFS_IRQ_ENABLE_SET    6'h35
`define OFS_IRQ_FLAGS         6'h36
`define OFS_RESET_CAUSE_LOG   6'h38

// Field positions
`define BIT_FAILURE_DET_EN    2
`define BIT_BACKUP_CLK_SEL    4
`define BIT_CLOCK_READY       0
`define BIT_CLOCK_FAILURE     1

// Access sizes
`define SIZE_BYTE             2'h0
`define SIZE_HALF             2'h1
`define SIZE_WORD             2'h2

// Idle depth codes
`define IDLE_CORE             2'h0
`define IDLE_CORE_HS          2'h1
`define IDLE_CORE_HS_PB       2'h2

// Reset values and writable-bit masks
`define RST_HS_GATES          32'h0000001F
`define RST_BUS_A_GATES       32'h0000007F
`define RST_BUS_B_GATES       32'h0000000F
`define RST_BUS_C_GATES       32'h00000000
`define MASK_HS_GATES         32'h0000001F
`define MASK_BUS_A_GATES      32'h0000007F
`define MASK_BUS_B_GATES      32'h0000000F
`define MASK_BUS_C_GATES      32'h000FFFFF
`endif

// *** dv/power_clock_manager_regs_assertions.sv ***
// Port-level checker for the power clock manager register bank
`timescale 1ns/100ps
module power_clock_manager_regs_assertions
(
    // Clock, reset and register port
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Guard, events and sleep requests
    input wire logic        access_guard_lock,
    input wire logic        clock_ready_evt,
    input wire logic        clock_failure_evt,
    input wire logic        wait_for_interrupt_instr,
    input wire logic        wake_request,
    // Control outputs
    input wire logic        backup_clock_select,
    input wire logic        failure_detector_enable,
    input wire logic        core_domain_stop,
    input wire logic        hs_domain_stop,
    input wire logic        pb_domain_stop,
    input wire logic [31:0] hs_clock_gates,
    input wire logic [31:0] bus_a_clock_gates,
    input wire logic        irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Read data only moves on a read
    AST_RDATA_STANDS: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_FAIL_SWITCH: assert property (clock_failure_evt && failure_detector_enable && !reg_wr
        |=> backup_clock_select && failure_detector_enable) else $error("no switch on failure");
    AST_BACKUP_HOLD: assert property (!reg_wr && !clock_failure_evt
        |=> $stable(backup_clock_select)) else $error("backup select moved on its own");
    // Guarded gate masks cannot move while locked
    AST_LOCK_GATES: assert property (access_guard_lock
        |=> $stable(hs_clock_gates) && $stable(bus_a_clock_gates)) else $error("locked write landed");
    AST_IDLE_NEST: assert property ((pb_domain_stop |-> hs_domain_stop)
        and (hs_domain_stop |-> core_domain_stop)) else $error("idle domains not nested");
    AST_WFI_STOP: assert property (wait_for_interrupt_instr && !wake_request
        |=> core_domain_stop) else $error("core kept running after sleep request");
    AST_WAKE_RUN: assert property (wake_request |=> !core_domain_stop[*2])
        else $error("core still stopped after wake");
    // Interrupt can only rise after an event or a register write
    AST_IRQ_CAUSE: assert property ($rose(irq)
        |-> $past(clock_ready_evt || clock_failure_evt || reg_wr)) else $error("irq rose uncaused");
    COV_FAIL: cover property (clock_failure_evt && failure_detector_enable);
    COV_DEEP: cover property (pb_domain_stop);
    COV_IRQ: cover property ($fell(irq));
endmodule // power_clock_manager_regs_assertions

bind power_clock_manager_regs power_clock_manager_regs_assertions u_chk
(
    .sys_clk, .resetn, .reg_wr, .reg_rd, .reg_rdata, .access_guard_lock,
    .clock_ready_evt, .clock_failure_evt, .wait_for_interrupt_instr, .wake_request,
    .backup_clock_select, .failure_detector_enable, .core_domain_stop, .hs_domain_stop,
    .pb_domain_stop, .hs_clock_gates, .bus_a_clock_gates, .irq
);

// *** dv/osc_event_model.sv ***
// Oscillator event source model: delayed one-cycle ready and failure pulses
`timescale 1ns/100ps
module osc_event_model #(parameter int LAT = 0)
(
    // Clock
    input  wire logic       sys_clk,
    // Requests from the bench, bit 0 ready, bit 1 failure
    input  wire logic [1:0] kick,
    // Pulses toward the block
    output wire logic [1:0] evt
);
    logic [1:0] pipe [8] = '{default: 2'h0};
    // Delay line; a slow oscillator is a larger latency
    always @(posedge sys_clk)
    begin
        pipe[0] <= kick;
        for (int i = 1; i < 8; i++)
            pipe[i] <= pipe[i - 1];
    end
    assign evt = pipe[LAT];
endmodule // osc_event_model

// *** dv/test_power_clock_manager_regs.sv ***
// Self-checking bench for the power clock manager register bank
`timescale 1ns/100ps
module test_power_clock_manager_regs;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [5:0]  reg_addr = 6'h00;
    logic [1:0]  reg_size = 2'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        access_guard_lock = 1'b0;
    logic [1:0]  kick = 2'h0;
    logic [1:0]  sleep_req = 2'h0;
    wire  [1:0]  evt;
    wire  [31:0] reg_rdata;
    wire  [31:0] gates [4];
    wire  [2:0]  stops;
    wire         core_en, a_en, b_en, c_en, irq;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          na, nb, nx, nc;

    power_clock_manager_regs uut
    (
        .sys_clk, .resetn, .reg_addr, .reg_size, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .access_guard_lock, .clock_ready_evt(evt[0]), .clock_failure_evt(evt[1]),
        .wait_for_interrupt_instr(sleep_req[0]), .wake_request(sleep_req[1]),
        .reset_cause_in(6'h04), .backup_clock_select(), .failure_detector_enable(),
        .core_clk_en(core_en), .bus_a_clk_en(a_en), .bus_b_clk_en(b_en), .bus_c_clk_en(c_en),
        .core_domain_stop(stops[0]), .hs_domain_stop(stops[1]), .pb_domain_stop(stops[2]),
        .hs_clock_gates(gates[0]), .bus_a_clock_gates(gates[1]),
        .bus_b_clock_gates(gates[2]), .bus_c_clock_gates(gates[3]), .irq
    );
    osc_event_model #(.LAT(2)) osc (.sys_clk, .kick, .evt);

    // 100 MHz clock
    initial
        forever #5 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle write; returns just after the edge that took it
    task automatic wr(input logic [5:0] a, input logic [1:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_size, reg_wdata} <= {1'b1, a, s, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [5:0] a, input logic [1:0] s, input logic [31:0] exp);
        @(posedge sys_clk);
        {reg_rd, reg_addr, reg_size} <= {1'b1, a, s};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata, exp);
    endtask
    // Pulse wake, sleep or oscillator requests, then let them land
    task automatic strobe(input logic [3:0] v);
        @(posedge sys_clk);
        {sleep_req, kick} <= v;
        @(posedge sys_clk);
        {sleep_req, kick} <= 4'h0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(6'h00, 2'h0, 32'h0);
        rd(6'h14, 2'h2, 32'h1F);
        rd(6'h18, 2'h2, 32'h7F);
        rd(6'h1C, 2'h2, 32'h0F);
        rd(6'h38, 2'h0, 32'h04);
        wr(6'h38, 2'h0, 32'hFF);
        rd(6'h38, 2'h0, 32'h04);
        rd(6'h04, 2'h0, 32'h0);
        // Byte and half lanes of a wide register
        wr(6'h20, 2'h2, 32'hFFFFFFFF);
        rd(6'h20, 2'h2, 32'h000FFFFF);
        wr(6'h22, 2'h1, 32'h0003);
        wr(6'h21, 2'h0, 32'h00);
        rd(6'h20, 2'h2, 32'h000300FF);
        rd(6'h22, 2'h0, 32'h03);
        rd(6'h20, 2'h1, 32'h00FF);
        chk("gates", gates[3], 32'h000300FF);
        wr(6'h14, 2'h0, 32'h0);
        chk("gates", gates[0], 32'h0);
        // Every prescaler code, counted over a whole 256-cycle span
        for (int i = 0; i < 8; i++)
        begin
            wr(6'h08, 2'h0, i);
            wr(6'h09, 2'h0, i);
            wr(6'h0A, 2'h0, i);
            wr(6'h0B, 2'h0, i);
            na = 0;
            nb = 0;
            nx = 0;
            nc = 0;
            repeat (256)
            begin
                @(posedge sys_clk);
                na += a_en;
                nb += b_en;
                nx += c_en;
                nc += core_en;
            end
            chk("bus_b_div", nb, 256 >> i);
            chk("bus_c_div", nx, 256 >> i);
            chk("core_div", nc, 256 >> i);
            chk("bus_a_div", na, 256 >> i);
        end
        // Guard lock: select ignores writes, interrupt enables do not
        @(posedge sys_clk);
        access_guard_lock <= 1'b1;
        wr(6'h08, 2'h0, 32'h2);
        wr(6'h35, 2'h0, 32'h3);
        rd(6'h08, 2'h0, 32'h7);
        @(posedge sys_clk);
        access_guard_lock <= 1'b0;
        wr(6'h08, 2'h0, 32'h2);
        rd(6'h08, 2'h0, 32'h2);
        // Flags, enables and the interrupt line
        rd(6'h35, 2'h0, 32'h3);
        strobe(4'h1);
        rd(6'h36, 2'h0, 32'h1);
        chk("irq", irq, 1'b1);
        wr(6'h36, 2'h0, 32'h0);
        rd(6'h36, 2'h0, 32'h1);
        wr(6'h34, 2'h0, 32'h1);
        chk("irq", irq, 1'b0);
        rd(6'h34, 2'h0, 32'h2);
        wr(6'h35, 2'h0, 32'h1);
        chk("irq", irq, 1'b1);
        wr(6'h36, 2'h0, 32'h1);
        chk("irq", irq, 1'b0);
        strobe(4'h2);
        rd(6'h36, 2'h0, 32'h0);
        wr(6'h00, 2'h0, 32'h4);
        strobe(4'h2);
        rd(6'h00, 2'h0, 32'h14);
        rd(6'h36, 2'h0, 32'h2);
        chk("irq", irq, 1'b1);
        wr(6'h36, 2'h0, 32'h2);
        chk("irq", irq, 1'b0);
        // Each idle depth, then wake
        for (int d = 0; d < 4; d++)
        begin
            wr(6'h01, 2'h0, d);
            strobe(4'h4);
            chk("stops", stops, d == 0 ? 3'h1 : d == 1 ? 3'h3 : 3'h7);
            strobe(4'h8);
            chk("stops", stops, 3'h0);
        end
        complete_run();
    end

    // Watchdog; the sequence needs under 5000 cycles
    initial
    begin
        #200000;
        error_cnt++;
        complete_run();
    end
endmodule // test_power_clock_manager_regs
